// file: pkg/vmc_cfg.svh
// offsets, field positions, reset values and timing counts of the vector motor control core
`ifndef VMC_CFG_SVH
`define VMC_CFG_SVH
`define VMC_ADR_DRIVE_CTRL 8'h00
`define VMC_ADR_CR1       8'h04
`define VMC_ADR_CR2       8'h08
`define VMC_ADR_IDREF     8'h0c
`define VMC_ADR_IQREF     8'h10
`define VMC_ADR_KP        8'h14
`define VMC_ADR_KI        8'h18
`define VMC_ADR_DMAX      8'h1c
`define VMC_ADR_DMIN      8'h20
`define VMC_ADR_QMAX      8'h24
`define VMC_ADR_QMIN      8'h28
`define VMC_ADR_THETA     8'h2c
`define VMC_ADR_TSMIN     8'h30
`define VMC_ADR_PERIOD    8'h34
`define VMC_ADR_ID        8'h38
`define VMC_ADR_IQ        8'h3c
`define VMC_ADR_UD        8'h40
`define VMC_ADR_UQ        8'h44
`define VMC_ADR_SPEED     8'h48
`define VMC_ADR_STATUS    8'h4c
`define VMC_BIT_ENABLE    0
`define VMC_BIT_SENSORED  2
`define VMC_BIT_SEGMODE   0
`define VMC_RST_WORD      16'h0000
`define VMC_RST_PERIOD    16'h0400
`define VMC_SPEED_SHIFT   3
`endif

// file: pkg/vmc_pkg.sv
// types of the vector motor control core
package vmc_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_CLARKE, ST_PARK, ST_PI, ST_IPARK, ST_MOD} vmc_step_t;
    typedef struct packed {
        logic signed [15:0] ia;
        logic signed [15:0] ib;
        logic signed [15:0] ic;
    } vmc_phase_t;
    typedef struct packed {
        logic [2:0] hi;
        logic [2:0] lo;
    } vmc_gate_t;
    typedef struct packed {
        logic               en;
        logic [1:0]         shunt_sampling_select;
        logic               sensored;
        logic               segment_mode_select;
        logic signed [15:0] idref, iqref, kp, ki, dmax, dmin, qmax, qmin;
        logic [15:0]        theta_sw, tsmin, period;
        logic signed [15:0] ialp, ibet, idm, iqm;
        logic signed [31:0] dint, qint;
        logic signed [15:0] ud, uq, valp, vbet;
        logic [15:0]        theta_est, theta_prev, speed;
        logic [15:0]        cnt, ca, cb, cc;
        logic               dir_dn;
        vmc_step_t          step;
        vmc_gate_t          gate;
        logic [2:0]         vector;
        logic               ack;
        logic [31:0]        rdat;
    } vmc_state_t;
endpackage

// file: core/vmc_core.sv
// vector motor control engine with a classic wishbone register slave
//
// Behaviour
// - enable bit low stops engine entirely
// - disabled engine holds resets, ignores writes except to the enable bit
// - d regulator: idref minus id, clamped output
// - q regulator: iqref minus iq, clamped output
// - inverse park rotates ud, uq by angle
// - inverse clarke gives three phase references
// - clarke turns phase currents into alpha, beta
// - park turns alpha, beta into id, iq
// - sensored angle from processor, else estimator
// - publish estimated speed for software
// - state bits c,b,a; 000/111 zero vectors
// - active vector alpha/beta values per table
// - adjacent vectors 2T1, 2T2, zero remainder
// - never both switches of a phase on
// - single shunt forces continuous modulation
// - dual/triple shunt, segment bit 0 continuous
// - discontinuous only dual/triple, segment bit 1
// - dual/triple shunt applies deadtime compensation
// - sampling field 00 single, 1x dual/triple
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "vmc_cfg.svh"
module vmc_core
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst_b,
    input  wire logic                   clk_en,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    input  wire vmc_pkg::vmc_phase_t    phase_current,
    output vmc_pkg::vmc_gate_t          gate_drive,
    output logic      [2:0]             inverter_vector
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // q15 multiply, result keeps q15 scaling
    function automatic logic signed [15:0] qmul(input logic signed [15:0] a, input logic signed [15:0] b);
        logic signed [31:0] p;
        p = a * b;
        qmul = p[30:15];
    endfunction

    // saturating clamp between lower and upper limit
    function automatic logic signed [15:0] clamp(input logic signed [31:0] v,
                                                 input logic signed [15:0] hi,
                                                 input logic signed [15:0] lo);
        if (v > 32'(hi))
            clamp = hi;
        else if (v < 32'(lo))
            clamp = lo;
        else
            clamp = v[15:0];
    endfunction

    // coarse sine by parabola, angle full scale 16 bits
    function automatic logic signed [15:0] qsin(input logic [15:0] ang);
        logic signed [16:0] x;
        logic signed [15:0] t;
        logic signed [15:0] r;
        x = {1'b0, ang[14:0], 1'b0} - 17'sh08000;
        t = x[15:0];
        r = 16'sh7fff - qmul(t, t);
        qsin = ang[15] ? -r : r;
    endfunction

    // phase reference to compare level, centred on half period
    function automatic logic [15:0] duty(input logic signed [15:0] v, input logic [15:0] per);
        logic signed [31:0] p;
        p = $signed({16'h0000, per}) * 32'(v);
        duty = per[15:1] + p[30:15];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    vmc_pkg::vmc_state_t s_q;
    vmc_pkg::vmc_state_t s_d;

    logic signed [15:0] sn;
    logic signed [15:0] cs;
    logic               wr;
    logic signed [31:0] ed;
    logic signed [31:0] eq;
    logic signed [31:0] ad;
    logic signed [31:0] aq;
    logic signed [15:0] va;
    logic signed [15:0] vb;
    logic signed [15:0] vc;
    logic signed [15:0] vmin;
    logic               dpwm;
    logic [15:0]        comp;
    logic [2:0]         hi;

    // pins in from the inverter pass three flops; used once two and three agree
    vmc_pkg::vmc_phase_t sync1_q, sync2_q, sync3_q, cur_q;
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            cur_q   <= '0;
        end
        else if (clk_en)
        begin
            sync1_q <= phase_current;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q == sync3_q)
                cur_q <= sync3_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        s_d  = s_q;
        wr   = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack;
        ed   = 32'(s_q.idref) - 32'(s_q.idm);
        eq   = 32'(s_q.iqref) - 32'(s_q.iqm);
        ad   = s_q.dint + 32'(qmul(s_q.ki, ed[15:0]));
        aq   = s_q.qint + 32'(qmul(s_q.ki, eq[15:0]));
        // angle source: processor in sensored mode, estimator otherwise
        sn   = qsin(s_q.sensored ? s_q.theta_sw : s_q.theta_est);
        cs   = qsin((s_q.sensored ? s_q.theta_sw : s_q.theta_est) + 16'h4000);
        // inverse clarke from alpha/beta voltage
        va   = s_q.valp;
        vb   = 16'((-32'(s_q.valp) + 32'(qmul(16'sh6ed9, s_q.vbet) <<< 1)) >>> 1);
        vc   = 16'((-32'(s_q.valp) - 32'(qmul(16'sh6ed9, s_q.vbet) <<< 1)) >>> 1);
        vmin = (va < vb) ? ((va < vc) ? va : vc) : ((vb < vc) ? vb : vc);
        // discontinuous only when shunt field is 1x and segment bit set
        dpwm = s_q.shunt_sampling_select[1] && s_q.segment_mode_select;
        comp = s_q.shunt_sampling_select[1] ? s_q.tsmin : 16'h0000;
        s_d.ack = 1'b0;

        // wishbone slave: one wait state, ack for one cycle
        if (wb_cyc_i && wb_stb_i && !s_q.ack)
        begin
            s_d.ack  = 1'b1;
            s_d.rdat = 32'h0000_0000;
            case (wb_adr_i)
                `VMC_ADR_DRIVE_CTRL: s_d.rdat = {31'h0, s_q.en};
                `VMC_ADR_CR1:     s_d.rdat = {29'h0, s_q.sensored, s_q.shunt_sampling_select};
                `VMC_ADR_CR2:     s_d.rdat = {31'h0, s_q.segment_mode_select};
                `VMC_ADR_IDREF:   s_d.rdat = {16'h0, s_q.idref};
                `VMC_ADR_IQREF:   s_d.rdat = {16'h0, s_q.iqref};
                `VMC_ADR_KP:      s_d.rdat = {16'h0, s_q.kp};
                `VMC_ADR_KI:      s_d.rdat = {16'h0, s_q.ki};
                `VMC_ADR_DMAX:    s_d.rdat = {16'h0, s_q.dmax};
                `VMC_ADR_DMIN:    s_d.rdat = {16'h0, s_q.dmin};
                `VMC_ADR_QMAX:    s_d.rdat = {16'h0, s_q.qmax};
                `VMC_ADR_QMIN:    s_d.rdat = {16'h0, s_q.qmin};
                `VMC_ADR_THETA:   s_d.rdat = {16'h0, s_q.theta_sw};
                `VMC_ADR_TSMIN:   s_d.rdat = {16'h0, s_q.tsmin};
                `VMC_ADR_PERIOD:  s_d.rdat = {16'h0, s_q.period};
                `VMC_ADR_ID:      s_d.rdat = {16'h0, s_q.idm};
                `VMC_ADR_IQ:      s_d.rdat = {16'h0, s_q.iqm};
                `VMC_ADR_UD:      s_d.rdat = {16'h0, s_q.ud};
                `VMC_ADR_UQ:      s_d.rdat = {16'h0, s_q.uq};
                `VMC_ADR_SPEED:   s_d.rdat = {16'h0, s_q.speed};
                `VMC_ADR_STATUS:  s_d.rdat = {25'h0, s_q.vector, 1'b0, s_q.step};
                default:          s_d.rdat = 32'h0000_0000;
            endcase
        end

        // enable bit always writable; it is the gate that keeps everything else
        if (wr && wb_adr_i == `VMC_ADR_DRIVE_CTRL && wb_sel_i[0])
            s_d.en = wb_dat_i[`VMC_BIT_ENABLE];

        if (wr && s_q.en)
        begin
            case (wb_adr_i)
                `VMC_ADR_CR1:
                begin
                    if (wb_sel_i[0])
                    begin
                        s_d.shunt_sampling_select = wb_dat_i[1:0];
                        s_d.sensored              = wb_dat_i[`VMC_BIT_SENSORED];
                    end
                end
                `VMC_ADR_CR2:    if (wb_sel_i[0]) s_d.segment_mode_select = wb_dat_i[`VMC_BIT_SEGMODE];
                `VMC_ADR_IDREF:  if (&wb_sel_i[1:0]) s_d.idref = wb_dat_i[15:0];
                `VMC_ADR_IQREF:  if (&wb_sel_i[1:0]) s_d.iqref = wb_dat_i[15:0];
                `VMC_ADR_KP:     if (&wb_sel_i[1:0]) s_d.kp = wb_dat_i[15:0];
                `VMC_ADR_KI:     if (&wb_sel_i[1:0]) s_d.ki = wb_dat_i[15:0];
                `VMC_ADR_DMAX:   if (&wb_sel_i[1:0]) s_d.dmax = wb_dat_i[15:0];
                `VMC_ADR_DMIN:   if (&wb_sel_i[1:0]) s_d.dmin = wb_dat_i[15:0];
                `VMC_ADR_QMAX:   if (&wb_sel_i[1:0]) s_d.qmax = wb_dat_i[15:0];
                `VMC_ADR_QMIN:   if (&wb_sel_i[1:0]) s_d.qmin = wb_dat_i[15:0];
                `VMC_ADR_THETA:  if (&wb_sel_i[1:0]) s_d.theta_sw = wb_dat_i[15:0];
                `VMC_ADR_TSMIN:  if (&wb_sel_i[1:0]) s_d.tsmin = wb_dat_i[15:0];
                `VMC_ADR_PERIOD: if (&wb_sel_i[1:0]) s_d.period = wb_dat_i[15:0];
                default:         s_d.dint = s_d.dint;
            endcase
        end

        // triangle carrier, one up and one down slope per pwm period
        if (s_q.en)
        begin
            if (s_q.dir_dn)
            begin
                if (s_q.cnt == 16'h0000)
                begin
                    s_d.dir_dn = 1'b0;
                    s_d.step   = vmc_pkg::ST_CLARKE;
                end
                else
                    s_d.cnt = s_q.cnt - 16'h0001;
            end
            else if (s_q.cnt >= s_q.period)
                s_d.dir_dn = 1'b1;
            else
                s_d.cnt = s_q.cnt + 16'h0001;
        end

        // control chain, one step per clock
        case (s_q.step)
            vmc_pkg::ST_IDLE: s_d.step = s_d.step;
            vmc_pkg::ST_CLARKE:
            begin
                s_d.ialp = cur_q.ia;
                s_d.ibet = qmul(16'sh49e7, 16'(32'(cur_q.ia) + (32'(cur_q.ib) <<< 1)));
                s_d.step = vmc_pkg::ST_PARK;
            end
            vmc_pkg::ST_PARK:
            begin
                s_d.idm  = 16'(32'(qmul(s_q.ialp, cs)) + 32'(qmul(s_q.ibet, sn)));
                s_d.iqm  = 16'(32'(qmul(s_q.ibet, cs)) - 32'(qmul(s_q.ialp, sn)));
                // angle estimate advances by the speed once per period; the estimate before the step is kept
                s_d.theta_prev = s_q.theta_est;
                s_d.theta_est  = s_q.theta_est + s_q.speed;
                s_d.step = vmc_pkg::ST_PI;
            end
            vmc_pkg::ST_PI:
            begin
                // integrator clamped too, so it cannot wind up past the limit
                s_d.dint = 32'(clamp(ad, s_q.dmax, s_q.dmin));
                s_d.qint = 32'(clamp(aq, s_q.qmax, s_q.qmin));
                s_d.ud   = clamp(ad + 32'(qmul(s_q.kp, ed[15:0])), s_q.dmax, s_q.dmin);
                s_d.uq   = clamp(aq + 32'(qmul(s_q.kp, eq[15:0])), s_q.qmax, s_q.qmin);
                if (s_q.sensored)
                    s_d.speed = s_q.speed + ((s_q.theta_sw - s_q.theta_prev - s_q.speed) >>> `VMC_SPEED_SHIFT);
                s_d.theta_prev = s_q.sensored ? s_q.theta_sw : s_q.theta_prev;
                s_d.step = vmc_pkg::ST_IPARK;
            end
            vmc_pkg::ST_IPARK:
            begin
                s_d.valp = 16'(32'(qmul(s_q.ud, cs)) - 32'(qmul(s_q.uq, sn)));
                s_d.vbet = 16'(32'(qmul(s_q.ud, sn)) + 32'(qmul(s_q.uq, cs)));
                s_d.step = vmc_pkg::ST_MOD;
            end
            vmc_pkg::ST_MOD:
            begin
                // compare levels; adjacent active vectors get 2T1 and 2T2, zero fills the rest
                // discontinuous: lowest phase pinned at -1/2, which duty maps to level 0 (never high)
                s_d.ca = duty(dpwm ? 16'(32'(va) - 32'(vmin) - 32'h4000) : va, s_q.period);
                s_d.cb = duty(dpwm ? 16'(32'(vb) - 32'(vmin) - 32'h4000) : vb, s_q.period);
                s_d.cc = duty(dpwm ? 16'(32'(vc) - 32'(vmin) - 32'h4000) : vc, s_q.period);
                s_d.step = vmc_pkg::ST_IDLE;
            end
            default: s_d.step = vmc_pkg::ST_IDLE;
        endcase

        // phase is high while carrier sits below its level; order c,b,a
        hi = {s_q.cnt < s_q.cc, s_q.cnt < s_q.cb, s_q.cnt < s_q.ca};
        s_d.vector = s_q.en ? hi : 3'b000;
        // deadtime: high side turns on only once the carrier is tsmin counts below its level (shunt field 1x); low side one clock after high off
        for (int i = 0; i < 3; i++)
        begin
            s_d.gate.hi[i] = s_q.en && hi[i] && !s_q.gate.lo[i] &&
                             (comp == 16'h0000 || s_q.cnt + comp < (i == 0 ? s_q.ca : i == 1 ? s_q.cb : s_q.cc)
                              || s_q.gate.hi[i]);
            s_d.gate.lo[i] = s_q.en && !hi[i] && !s_q.gate.hi[i];
        end

        // disabled: everything but the bus answer and the enable returns to reset
        if (!s_q.en)
        begin
            s_d        = '0;
            s_d.period = `VMC_RST_PERIOD;
            s_d.en     = (wr && wb_adr_i == `VMC_ADR_DRIVE_CTRL && wb_sel_i[0]) ? wb_dat_i[`VMC_BIT_ENABLE] : 1'b0;
            s_d.ack    = wb_cyc_i && wb_stb_i && !s_q.ack;
            s_d.rdat   = (wb_adr_i == `VMC_ADR_PERIOD) ? {16'h0, `VMC_RST_PERIOD} : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers; clk_en low freezes all state

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            s_q        <= '0;
            s_q.period <= `VMC_RST_PERIOD;
        end
        else if (clk_en)
            s_q <= s_d;
    end

    assign wb_ack_o        = s_q.ack;     // flop outputs
    assign wb_dat_o        = s_q.rdat;
    assign gate_drive      = s_q.gate;
    assign inverter_vector = s_q.vector;

endmodule // vmc_core

// file: test/vmc_core_props.sv
// port assertions of the vector motor control core
`timescale 1ns/10ps
`include "vmc_cfg.svh"
module vmc_core_props
(
    input wire logic                clk_sys,
    input wire logic                rst_b,
    input wire logic                clk_en,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [7:0]          wb_adr_i,
    input wire logic [3:0]          wb_sel_i,
    input wire logic [31:0]         wb_dat_i,
    input wire logic [31:0]         wb_dat_o,
    input wire logic                wb_ack_o,
    input wire vmc_pkg::vmc_phase_t phase_current,
    input wire vmc_pkg::vmc_gate_t  gate_drive,
    input wire logic [2:0]          inverter_vector
);
    logic en_q;
    logic rd_ack;
    // enable mirror, taken on the same edge as the slave takes a write
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            en_q <= 1'b0;
        else if (clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == `VMC_ADR_DRIVE_CTRL && wb_sel_i[0])
            en_q <= wb_dat_i[0];
    end
    assign rd_ack = wb_ack_o && !wb_we_i;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////
    chk_no_shoot_through:
    assert property (~|(gate_drive.hi & gate_drive.lo)) else $error("both switches of a phase on");
    chk_ack_one_wait:
    assert property (clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("answer late");
    chk_ack_drops:
    assert property (wb_ack_o && clk_en |=> !wb_ack_o) else $error("ack longer than one cycle");
    chk_ack_has_cause:
    assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    chk_upper_half_zero:
    assert property (rd_ack |-> wb_dat_o[31:16] == 16'h0000) else $error("upper read bits set");
    chk_unmapped_zero:
    assert property (rd_ack && wb_adr_i > `VMC_ADR_STATUS |-> wb_dat_o == 32'h0) else $error("unmapped read not 0");
    chk_off_reads_reset:
    assert property (rd_ack && !en_q |-> wb_dat_o == (wb_adr_i == `VMC_ADR_PERIOD ? {16'h0, `VMC_RST_PERIOD} : 32'h0))
        else $error("disabled read not reset value");
    chk_off_outputs_idle:
    assert property (!en_q && !$past(en_q) && $past(clk_en) |-> gate_drive == 6'h00 && inverter_vector == 3'h0)
        else $error("outputs active while disabled");
    chk_gate_within_vector:
    assert property (~|((gate_drive.hi & ~inverter_vector) | (gate_drive.lo & inverter_vector)))
        else $error("gate differs from commanded state");
    cover property (en_q && inverter_vector == 3'h7);
    cover property (rd_ack && en_q);
    cover property (en_q && gate_drive.hi != 3'h0);
endmodule // vmc_core_props

// file: test/vmc_inverter_model.sv
// winding model: phase currents follow the gate commands
`timescale 1ns/10ps
module vmc_inverter_model
(
    input  wire logic               clk_sys,
    input  wire logic               slow,
    input  wire vmc_pkg::vmc_gate_t gate_drive,
    output vmc_pkg::vmc_phase_t     phase_current = '0
);
    int cur [3] = '{0, 0, 0};
    int lvl [3];
    int tick = 0;
    // a slow plant moves only every fourth cycle; both switches off floats the winding
    always @(posedge clk_sys)
    begin
        tick = tick + 1;
        for (int k = 0; k < 3; k++)
            lvl[k] = gate_drive.hi[k] ? 1 : gate_drive.lo[k] ? -1 : 0;
        if (!slow || tick % 4 == 0)
            for (int k = 0; k < 3; k++)
                cur[k] = cur[k] - cur[k] / 16 + 16 * (3 * lvl[k] - lvl[0] - lvl[1] - lvl[2]);
        phase_current <= {16'(cur[0]), 16'(cur[1]), 16'(cur[2])};
    end
endmodule // vmc_inverter_model

// file: test/test_vector_motor_control_core.sv
// self-checking bench of the vector motor control core
`timescale 1ns/10ps
`include "vmc_cfg.svh"
module test_vector_motor_control_core;
    logic                clk_sys = 1'b0;
    logic                rst_b = 1'b0;
    logic                clk_en = 1'b1;
    logic                wb_cyc_i = 1'b0;
    logic                wb_stb_i = 1'b0;
    logic                wb_we_i = 1'b0;
    logic [7:0]          wb_adr_i = 8'h00;
    logic [3:0]          wb_sel_i = 4'h0;
    logic [31:0]         wb_dat_i = 32'h0;
    logic [31:0]         wb_dat_o;
    logic                wb_ack_o;
    vmc_pkg::vmc_phase_t phase_current;
    vmc_pkg::vmc_gate_t  gate_drive;
    logic [2:0]          inverter_vector;
    logic                slow = 1'b0;
    logic                jitter = 1'b0;
    logic [7:0]          seen = 8'h00;
    logic [31:0]         seed = 32'h5;
    logic [31:0]         v;
    logic [31:0]         d;
    logic [1:0]          sh;
    int                  err_total = 0;
    int                  checked = 0;
    int                  cycles = 0;
    logic [7:0]          cfg_a [9] = '{`VMC_ADR_CR1, `VMC_ADR_PERIOD, `VMC_ADR_KP, `VMC_ADR_KI, `VMC_ADR_DMAX,
                                      `VMC_ADR_DMIN, `VMC_ADR_QMAX, `VMC_ADR_QMIN, `VMC_ADR_THETA};
    logic [15:0]         cfg_d [9] = '{16'h0006, 16'h0040, 16'h7fff, 16'h0000, 16'h0800,
                                      16'hf800, 16'h0c00, 16'hf400, 16'h1555};
    vmc_core dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .phase_current(phase_current), .gate_drive(gate_drive),
        .inverter_vector(inverter_vector));
    vmc_inverter_model plant_u (.clk_sys(clk_sys), .slow(slow), .gate_drive(gate_drive),
        .phase_current(phase_current));
    always #4 clk_sys = ~clk_sys;
    // cycle ceiling, vector log, enable gaps when asked
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        seen[inverter_vector] <= 1'b1;
        clk_en <= !jitter || cycles % 3 != 0;
        if (cycles == 40000)
        begin
            err_total = err_total + 1;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] exp_reset(input logic [7:0] a);
        return a == `VMC_ADR_PERIOD ? {16'h0, `VMC_RST_PERIOD} : 32'h0;
    endfunction
    // at one sector at most two neighbouring active states, one bit apart
    function automatic logic adj_ok(input logic [7:0] s);
        logic ok;
        ok = $countones(s[6:1]) inside {[1:2]};
        for (int j = 1; j < 7; j++)
            for (int k = j + 1; k < 7; k++)
                if (s[j] && s[k] && $countones(j ^ k) != 1)
                    ok = 1'b0;
        return ok;
    endfunction
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // classic single cycle, held until ack is sampled
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= dat;
        @(posedge clk_sys);
        while (wb_ack_o !== 1'b1 && n < 100)
        begin
            @(posedge clk_sys);
            n++;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        check("bus answer", {31'h0, wb_ack_o}, 32'h1);
    endtask
    task automatic poll(input logic [7:0] adr, input logic [31:0] want);
        int n;
        n = 0;
        bus(1'b0, adr, 32'h0, v);
        while (v !== want && n < 40)
        begin
            repeat (130) @(posedge clk_sys);
            bus(1'b0, adr, 32'h0, v);
            n++;
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        // disabled engine: writes dropped, unmapped places too
        for (int a = 4; a < 8'h58; a += 4)
        begin
            bus(1'b1, 8'(a), rnd(), v);
            bus(1'b0, 8'(a), 32'h0, v);
            check("reset value", v, exp_reset(8'(a)));
        end
        check("idle outputs", {23'h0, gate_drive, inverter_vector}, 32'h0);
        bus(1'b1, `VMC_ADR_DRIVE_CTRL, 32'h1, v);
        bus(1'b0, `VMC_ADR_DRIVE_CTRL, 32'h0, v);
        check("enable bit", v, 32'h1);
        // settings read back with clock-enable gaps in between
        jitter <= 1'b1;
        for (int a = `VMC_ADR_IDREF; a <= `VMC_ADR_TSMIN; a += 4)
        begin
            d = rnd();
            bus(1'b1, 8'(a), d, v);
            bus(1'b0, 8'(a), 32'h0, v);
            check("read back", v, {16'h0, d[15:0]});
        end
        jitter <= 1'b0;
        // proportional-only regulators pushed into each limit; error sign decides which
        for (int k = 0; k < 9; k++)
            bus(1'b1, cfg_a[k], {16'h0, cfg_d[k]}, v);
        for (int k = 0; k < 2; k++)
        begin
            slow <= k[0];
            bus(1'b1, `VMC_ADR_IDREF, k ? 32'h9000 : 32'h7000, v);
            bus(1'b1, `VMC_ADR_IQREF, k ? 32'h7000 : 32'h9000, v);
            poll(`VMC_ADR_UD, k ? 32'hf800 : 32'h0800);
            check("d voltage", v, k ? 32'hf800 : 32'h0800);
            poll(`VMC_ADR_UQ, k ? 32'h0c00 : 32'hf400);
            check("q voltage", v, k ? 32'h0c00 : 32'hf400);
        end
        // sampling fields 00 to 11 at a fixed angle; segment bit 1 only with 01, 10 and 11, bit 0 with 00, 10 and 11
        for (int m = 0; m < 6; m++)
        begin
            sh = m < 2 ? {1'b0, m[0]} : m < 4 ? 2'b10 : 2'b11;
            bus(1'b1, `VMC_ADR_CR1, {29'h0, 1'b1, sh}, v);
            bus(1'b1, `VMC_ADR_CR2, {31'h0, m[0]}, v);
            repeat (300) @(posedge clk_sys);
            seen = 8'h00;
            repeat (600) @(posedge clk_sys);
            check("both zero states", {31'h0, seen[0] & seen[7]}, {31'h0, !(sh[1] && m[0])});
            check("adjacent pair", {31'h0, adj_ok(seen)}, 32'h1);
        end
        // a turning written angle walks all six sectors and shows as speed
        seen = 8'h00;
        for (int k = 0; k < 16; k++)
        begin
            bus(1'b1, `VMC_ADR_THETA, 32'(k * 16'h1000), v);
            repeat (260) @(posedge clk_sys);
        end
        check("all sectors", {26'h0, seen[6:1]}, 32'h3f);
        bus(1'b0, `VMC_ADR_SPEED, 32'h0, v);
        check("speed moving", {31'h0, v != 32'h0}, 32'h1);
        // stop in mid-run: settings fall back, outputs go quiet
        bus(1'b1, `VMC_ADR_DRIVE_CTRL, 32'h0, v);
        bus(1'b0, `VMC_ADR_PERIOD, 32'h0, v);
        check("period after stop", v, exp_reset(`VMC_ADR_PERIOD));
        check("stopped outputs", {23'h0, gate_drive, inverter_vector}, 32'h0);
        wrap_up();
    end
endmodule // test_vector_motor_control_core
bind vmc_core vmc_core_props chk_u (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phase_current(phase_current), .gate_drive(gate_drive),
    .inverter_vector(inverter_vector));
